// File: hbc_ctrl.sv
// host controller driving the half-bridge enable and direction pins
module hbc_ctrl
	import hbc_pkg::*;
#(
	parameter int RESET_CYC = HBC_RESET_PULSE_CYC,
	parameter int STEP_CYC = HBC_STEP_LOW_CYC,
	parameter int SKEW_CYC = HBC_SKEW_CYC,
	parameter int WAKE_CYC = HBC_WAKE_CYC
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// device pins
	input wire logic fault_i,
	output logic bridge_enable_input_o,
	output logic direction_o
);
	import hbc_pkg::*;
	initial begin
		if (WAKE_CYC < 1 || STEP_CYC < 1 || RESET_CYC < 1 || SKEW_CYC < 1 ||
				WAKE_CYC > 65535 || STEP_CYC > 65535 || RESET_CYC > 65535) begin
			$error("hbc_ctrl: timing parameter out of range");
		end
	end
	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		hbc_state_e state;
		logic [15:0] cnt;
		logic [2:0] target;
		logic [3:0] steps;
		logic [2:0] level;
		logic run;
		logic dir;
		logic en_pin;
		logic dir_pin;
		logic ack;
		logic [31:0] dat;
	} hbc_ctrl_s;
	hbc_ctrl_s st_r;
	hbc_ctrl_s st_nxt;
	logic fault_lvl;
	logic wb_req;
	hbc_sync u_fault_sync (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.pin_i(fault_i),
		.level_o(fault_lvl)
	);
	assign wb_req = wb_cyc_i && wb_stb_i && !st_r.ack;
	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		st_nxt = st_r;
		st_nxt.ack = wb_req;
		if (wb_req && !wb_we_i) begin
			case (wb_adr_i)
				HBC_ADR_CTRL: st_nxt.dat = {30'h0, st_r.dir, st_r.run};
				HBC_ADR_LEVEL: st_nxt.dat = {29'h0, st_r.target};
				HBC_ADR_STATUS: st_nxt.dat = {20'h0, st_r.state, 1'b0, st_r.level,
					2'h0, fault_lvl, st_r.state != HBC_IDLE};
				default: st_nxt.dat = 32'h0;
			endcase
		end
		if (wb_req && wb_we_i && wb_sel_i[0]) begin
			if (wb_adr_i == HBC_ADR_CTRL) begin
				st_nxt.run = wb_dat_i[HBC_CTRL_RUN_BIT];
				st_nxt.dir = wb_dat_i[HBC_CTRL_DIR_BIT];
			end
			if (wb_adr_i == HBC_ADR_LEVEL) begin
				st_nxt.target = wb_dat_i[2:0];
			end
		end
		if (st_r.cnt != 16'h0) begin
			st_nxt.cnt = st_r.cnt - 16'h1;
		end
		case (st_r.state)
			HBC_IDLE: begin
				// enable follows the run bit, with direction choosing the switch
				st_nxt.en_pin = st_r.run;
				st_nxt.dir_pin = st_r.dir;
				if (wb_req && wb_we_i && wb_sel_i[0] && wb_adr_i == HBC_ADR_CMD) begin
					if (wb_dat_i[HBC_CMD_CLEAR_BIT]) begin
						st_nxt.state = HBC_CLR_LOW;
						st_nxt.en_pin = 1'b0;
						st_nxt.dir_pin = 1'b0;
						st_nxt.cnt = RESET_CYC[15:0];
					end else if (wb_dat_i[HBC_CMD_PROG_BIT] && !fault_lvl) begin
						// enable drops first, direction rises a skew later
						st_nxt.state = HBC_SEL_SKEW;
						st_nxt.en_pin = 1'b0;
						st_nxt.dir_pin = 1'b0;
						st_nxt.cnt = SKEW_CYC[15:0];
					end
				end
			end
			HBC_CLR_LOW: begin
				if (st_r.cnt == 16'h0) begin
					// both low long enough, latch cleared
					st_nxt.state = HBC_IDLE;
					st_nxt.level = HBC_LEVEL_RST;
				end
			end
			HBC_SEL_SKEW: begin
				if (st_r.cnt == 16'h0) begin
					st_nxt.state = HBC_SEL_WAKE;
					st_nxt.dir_pin = 1'b1;
					st_nxt.cnt = WAKE_CYC[15:0];
					st_nxt.steps = 4'h0;
				end
			end
			HBC_SEL_WAKE: begin
				if (st_r.cnt == 16'h0) begin
					st_nxt.state = HBC_SEL_LOW;
					st_nxt.dir_pin = 1'b0;
					st_nxt.cnt = STEP_CYC[15:0];
				end
			end
			HBC_SEL_LOW: begin
				if (st_r.cnt == 16'h0) begin
					st_nxt.state = HBC_SEL_HIGH;
					st_nxt.dir_pin = 1'b1;
					st_nxt.cnt = STEP_CYC[15:0];
					if (st_r.steps != 4'h0) begin
						st_nxt.level = st_r.level + 3'h1;
					end
					st_nxt.steps = st_r.steps + 4'h1;
				end
			end
			HBC_SEL_HIGH: begin
				if (fault_lvl) begin
					// device left selection on the fault
					st_nxt.state = HBC_SEL_EXIT;
					st_nxt.dir_pin = 1'b0;
					st_nxt.cnt = SKEW_CYC[15:0];
				end else if (st_r.cnt == 16'h0) begin
					if (st_r.level == st_r.target && st_r.steps != 4'h0) begin
						st_nxt.state = HBC_SEL_EXIT;
						st_nxt.dir_pin = st_r.dir;
						st_nxt.cnt = SKEW_CYC[15:0];
					end else begin
						st_nxt.state = HBC_SEL_LOW;
						st_nxt.dir_pin = 1'b0;
						st_nxt.cnt = STEP_CYC[15:0];
					end
				end
			end
			HBC_SEL_EXIT: begin
				if (st_r.cnt == 16'h0) begin
					// back to idle, where enable follows the run bit
					st_nxt.state = HBC_IDLE;
				end
			end
			default: begin
				st_nxt.state = HBC_IDLE;
			end
		endcase
	end
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end
	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign wb_dat_o = st_r.dat;
	assign wb_ack_o = st_r.ack;
	assign bridge_enable_input_o = st_r.en_pin;
	assign direction_o = st_r.dir_pin;
	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	property p_sel_enable_low;
		@(posedge clk_i) disable iff (rst_i)
		(st_r.state == HBC_SEL_LOW) |-> !bridge_enable_input_o;
	endproperty
	a_sel_enable_low: assert property (p_sel_enable_low) else $error("enable high in step");
	property p_clear_both_low;
		@(posedge clk_i) disable iff (rst_i)
		(st_r.state == HBC_CLR_LOW) |-> !bridge_enable_input_o && !direction_o;
	endproperty
	a_clear_both_low: assert property (p_clear_both_low) else $error("clear pulse broken");
	property p_wrap;
		@(posedge clk_i) disable iff (rst_i)
		(st_r.state == HBC_SEL_LOW && st_r.cnt == 16'h0 && st_r.steps != 4'h0)
			|=> st_r.level == $past(st_r.level) + 3'h1;
	endproperty
	a_wrap: assert property (p_wrap) else $error("level not advanced");
	property p_ack_one;
		@(posedge clk_i) disable iff (rst_i)
		wb_ack_o |=> !wb_ack_o;
	endproperty
	a_ack_one: assert property (p_ack_one) else $error("ack held");
	property p_skew_both_low;
		@(posedge clk_i) disable iff (rst_i)
		(st_r.state == HBC_SEL_SKEW) |-> !bridge_enable_input_o && !direction_o;
	endproperty
	a_skew_both_low: assert property (p_skew_both_low) else $error("skew edges together");
endmodule

// File: hbc_pkg.sv
// package: constants and types of the half-bridge host controller
package hbc_pkg;
	// ----------------------------------------------------------------
	// register map of the controller (word offsets as byte addresses)
	// ----------------------------------------------------------------
	localparam logic [3:0] HBC_ADR_CTRL = 4'h0;
	localparam logic [3:0] HBC_ADR_LEVEL = 4'h4;
	localparam logic [3:0] HBC_ADR_STATUS = 4'h8;
	localparam logic [3:0] HBC_ADR_CMD = 4'hC;
	// ctrl fields
	localparam int HBC_CTRL_RUN_BIT = 0;
	localparam int HBC_CTRL_DIR_BIT = 1;
	// cmd fields
	localparam int HBC_CMD_CLEAR_BIT = 0;
	localparam int HBC_CMD_PROG_BIT = 1;
	// status fields
	localparam int HBC_ST_BUSY_BIT = 0;
	localparam int HBC_ST_FAULT_BIT = 1;
	localparam int HBC_ST_LEVEL_LSB = 4;
	localparam int HBC_ST_STATE_LSB = 8;
	// reset values
	localparam logic [2:0] HBC_LEVEL_RST = 3'h0;
	localparam int HBC_LEVELS = 8;
	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int HBC_CLK_MHZ = 100;
	localparam int HBC_RESET_PULSE_US = 9;
	localparam int HBC_RESET_PULSE_CYC = HBC_RESET_PULSE_US * HBC_CLK_MHZ;
	localparam int HBC_STEP_LOW_US = 10;
	localparam int HBC_STEP_LOW_CYC = HBC_STEP_LOW_US * HBC_CLK_MHZ;
	localparam int HBC_SKEW_US = 2;
	localparam int HBC_SKEW_CYC = HBC_SKEW_US * HBC_CLK_MHZ;
	localparam int HBC_WAKE_US = 50;
	localparam int HBC_WAKE_CYC = HBC_WAKE_US * HBC_CLK_MHZ;
	// ----------------------------------------------------------------
	// controller states
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		HBC_IDLE,
		HBC_CLR_LOW,
		HBC_SEL_SKEW,
		HBC_SEL_WAKE,
		HBC_SEL_LOW,
		HBC_SEL_HIGH,
		HBC_SEL_EXIT
	} hbc_state_e;
endpackage

// File: hbc_sync.sv
// three-stage input synchroniser with agree filter
module hbc_sync (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// pin and clean level
	input wire logic pin_i,
	output logic level_o
);
	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic lvl;
	} hbc_sync_s;
	hbc_sync_s st_r;
	hbc_sync_s st_nxt;
	always_comb begin
		st_nxt = st_r;
		st_nxt.s1 = pin_i;
		st_nxt.s2 = st_r.s1;
		st_nxt.s3 = st_r.s2;
		if (st_r.s2 == st_r.s3) begin
			st_nxt.lvl = st_r.s3;
		end
	end
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end
	assign level_o = st_r.lvl;
endmodule

// File: hbc_dev_model.sv
// behavioural model of the half-bridge device as seen from its logic pins
module hbc_dev_model #(
	parameter int RESET_CYC = 4,
	parameter int STEP_CYC = 4
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// pins and fault stimulus
	input wire logic bridge_enable_input_i,
	input wire logic direction_i,
	input wire logic fault_req_i,
	output logic fault_o,
	output logic [2:0] level_o
);
	timeunit 1ns;
	timeprecision 1ps;
	int low_n;
	int both_n;
	logic dir_q;
	logic in_mode;
	logic seen;
	always @(posedge clk_i) begin
		if (rst_i) begin
			level_o <= 3'h0;
			fault_o <= 1'b0;
			low_n <= 0;
			both_n <= 0;
			dir_q <= 1'b0;
			in_mode <= 1'b0;
			seen <= 1'b0;
		end else begin
			dir_q <= direction_i;
			low_n <= direction_i ? 0 : low_n + 1;
			both_n <= (!bridge_enable_input_i && !direction_i) ? both_n + 1 : 0;
			if (fault_req_i) begin
				fault_o <= 1'b1;
			end else if (both_n >= RESET_CYC) begin
				fault_o <= 1'b0;
			end
			if (bridge_enable_input_i || fault_o) begin
				in_mode <= 1'b0;
				seen <= 1'b0;
			end else if (direction_i && !dir_q && in_mode && low_n >= STEP_CYC) begin
				if (seen) begin
					level_o <= level_o + 3'h1;
				end
				seen <= 1'b1;
			end else if (direction_i) begin
				in_mode <= 1'b1;
			end
		end
	end
endmodule

// File: half_bridge_protect_slew_ctrl_tb.sv
// testbench: wishbone-driven host controller against the device model
module half_bridge_protect_slew_ctrl_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import hbc_pkg::*;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc = 1'b0, stb = 1'b0, we = 1'b0, fault_req = 1'b0;
	logic [3:0] adr = 4'h0, sel = 4'h0;
	logic [31:0] wdat = 32'h0, rdat, d;
	logic ack, fault, en, dir;
	logic [2:0] lvl;
	int n_errors = 0;
	int num_checks = 0;
	always #5 clk_i = ~clk_i;
	hbc_ctrl #(.RESET_CYC(4), .STEP_CYC(4), .SKEW_CYC(4), .WAKE_CYC(4)) i_dut (
		.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.fault_i(fault), .bridge_enable_input_o(en), .direction_o(dir));
	// the model's default timing counts match the controller's overrides above
	hbc_dev_model i_dev (
		.clk_i(clk_i), .rst_i(rst_i), .bridge_enable_input_i(en), .direction_i(dir),
		.fault_req_i(fault_req), .fault_o(fault), .level_o(lvl));
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		num_checks++;
		if (g !== e) begin
			n_errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	// one classic cycle: request held until ack is seen high at a rising edge
	task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] v);
		int n;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= 4'hF;
		wdat <= v;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1 && n < 50);
		if (n >= 50) begin
			n_errors++;
			final_report();
		end
		d = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic wait_idle();
		int n;
		n = 0;
		do begin
			wb(1'b0, HBC_ADR_STATUS, 32'h0);
			n++;
		end while (d[HBC_ST_BUSY_BIT] !== 1'b0 && n < 100);
		chk({31'h0, d[HBC_ST_BUSY_BIT]}, 32'h0);
	endtask
	task automatic prog(input logic [2:0] t);
		wb(1'b1, HBC_ADR_LEVEL, {29'h0, t});
		wb(1'b1, HBC_ADR_CMD, 32'h2);
		wait_idle();
	endtask
	task automatic final_report();
		$display("checks=%0d errors=%0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clk_i);
		n_errors++;
		final_report();
	end
	initial begin
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		wb(1'b0, HBC_ADR_STATUS, 32'h0);
		chk(d, 32'h0);
		wb(1'b0, 4'h2, 32'h0);
		chk(d, 32'h0);
		$display("test reset done");
		wb(1'b1, HBC_ADR_CTRL, 32'h3);
		@(negedge clk_i);
		chk({30'h0, en, dir}, 32'h3);
		wb(1'b1, HBC_ADR_CTRL, 32'h1);
		@(negedge clk_i);
		chk({30'h0, en, dir}, 32'h2);
		$display("test drive done");
		wb(1'b1, HBC_ADR_CTRL, 32'h0);
		prog(3'h3);
		chk({29'h0, lvl}, 32'h3);
		chk({29'h0, d[6:4]}, 32'h3);
		// enable high takes the device out of selection before the next run
		wb(1'b1, HBC_ADR_CTRL, 32'h1);
		prog(3'h1);
		chk({29'h0, lvl}, 32'h1);
		$display("test select done");
		fault_req <= 1'b1;
		@(posedge clk_i);
		fault_req <= 1'b0;
		repeat (6) @(posedge clk_i);
		wb(1'b0, HBC_ADR_STATUS, 32'h0);
		chk({31'h0, d[HBC_ST_FAULT_BIT]}, 32'h1);
		prog(3'h6);
		chk({29'h0, lvl}, 32'h1);
		chk({29'h0, d[6:4]}, 32'h1);
		wb(1'b1, HBC_ADR_CMD, 32'h1);
		wait_idle();
		chk({31'h0, fault}, 32'h0);
		repeat (6) @(posedge clk_i);
		wb(1'b0, HBC_ADR_STATUS, 32'h0);
		chk({31'h0, d[HBC_ST_FAULT_BIT]}, 32'h0);
		$display("test fault done");
		final_report();
	end
endmodule
